// [shared/exec_pkg.sv]
// constants shared by the instruction execute subset and its watchdog
package exec_pkg;
    localparam int PC_W = 21;
    localparam int DADDR_W = 12;
    localparam int FLAG_W = 5;
    // execution phases within one instruction cycle
    localparam logic [1:0] PH_DECODE = 2'h0;
    localparam logic [1:0] PH_READ = 2'h1;
    localparam logic [1:0] PH_PROCESS = 2'h2;
    localparam logic [1:0] PH_WRITE = 2'h3;
    // opcode patterns, compared against the upper bits of the word (the whole word for the watchdog clear)
    localparam logic [3:0] OP_BIT_INVERT = 4'h7;
    localparam logic [7:0] OP_BRANCH_OVF = 8'hE4;
    localparam logic [7:0] OP_BRANCH_ZERO = 8'hE0;
    localparam logic [6:0] OP_CALL = 7'h76;
    localparam logic [7:0] OP_JUMP_LONG = 8'hEF;
    localparam logic [6:0] OP_CLEAR_FILE = 7'h35;
    localparam logic [15:0] OP_WATCHDOG_CLEAR = 16'h0004;
    localparam logic [5:0] OP_COMPLEMENT = 6'h07;
    localparam logic [6:0] OP_CMP_EQUAL = 7'h31;
    localparam logic [6:0] OP_CMP_GREATER = 7'h32;
    localparam logic [6:0] OP_CMP_LESS = 7'h30;
    // data addressing
    localparam logic [7:0] ACCESS_LIMIT = 8'h5F;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
    // flag positions in the status vector
    localparam int FLAG_C = 0;
    localparam int FLAG_DC = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_OV = 3;
    localparam int FLAG_N = 4;
    localparam logic [4:0] MASK_Z = 5'h04;
    localparam logic [4:0] MASK_NZ = 5'h14;
    // program counter steps
    localparam logic [20:0] PC_STEP = 21'h000002;
    localparam logic [20:0] PC_RESET = 21'h000000;
    localparam logic [20:0] RET_OFS = 21'h000002;
    // reset values and watchdog widths
    localparam logic TIMEOUT_RST = 1'b1;
    localparam logic POWERDOWN_RST = 1'b1;
    localparam int WATCHDOG_CNT_W = 8;
    localparam int WATCHDOG_POST_W = 4;
endpackage

// [logic/watchdog_unit.sv]
// watchdog counter with postscaler, cleared by the watchdog clear opcode
`timescale 1ns/1ps
module watchdog_unit #(
    parameter int CNT_W = exec_pkg::WATCHDOG_CNT_W,
    parameter int POST_W = exec_pkg::WATCHDOG_POST_W
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clr,
    output logic timeout
);
    import exec_pkg::*;

    generate
        if (CNT_W < 1 || POST_W < 1) begin : g_bad
            $error("watchdog widths must be at least one bit");
        end
    endgenerate

    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [POST_W-1:0] post_r, post_nxt;
    logic timeout_r, timeout_nxt;

    always_comb begin
        cnt_nxt = cnt_r + 1'b1;
        post_nxt = post_r;
        timeout_nxt = 1'b0;
        if (clr) begin
            // clearing zeroes the postscaler too, so a late clear never leaves a partial count
            cnt_nxt = '0;
            post_nxt = '0;
        end else if (&cnt_r) begin
            post_nxt = post_r + 1'b1;
            timeout_nxt = &post_r;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= '0;
            post_r <= '0;
            timeout_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            post_r <= post_nxt;
            timeout_r <= timeout_nxt;
        end
    end

    assign timeout = timeout_r;
endmodule

// [logic/instr_exec.sv]
// decode and execute of a subset of the 8-bit core instruction set
`timescale 1ns/1ps
module instr_exec (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [15:0] instr_word,
    input wire logic ext_set_en,
    input wire logic [exec_pkg::DADDR_W-1:0] index_base,
    input wire logic [7:0] working_register,
    input wire logic [exec_pkg::FLAG_W-1:0] status_in,
    input wire logic [7:0] bank_select_reg,
    input wire logic [7:0] dmem_rdata,
    output logic [exec_pkg::PC_W-1:0] fetch_addr,
    output logic [1:0] phase,
    output logic [exec_pkg::DADDR_W-1:0] dmem_addr,
    output logic dmem_re,
    output logic dmem_we,
    output logic [7:0] dmem_wdata,
    output logic w_we,
    output logic [7:0] w_wdata,
    output logic [exec_pkg::FLAG_W-1:0] flags_we,
    output logic [exec_pkg::FLAG_W-1:0] flags_wdata,
    output logic ret_push,
    output logic [exec_pkg::PC_W-1:0] return_stack_top,
    output logic [7:0] working_shadow,
    output logic [exec_pkg::FLAG_W-1:0] flags_shadow,
    output logic [7:0] bank_select_shadow,
    output logic timeout_flag,
    output logic powerdown_flag
);
    import exec_pkg::*;

    function automatic logic two_word(input logic [15:0] w);
        two_word = (w[15:9] == OP_CALL) || (w[15:8] == OP_JUMP_LONG);
    endfunction

    function automatic logic [DADDR_W-1:0] file_addr(input logic [15:0] w, input logic ext,
                                                     input logic [DADDR_W-1:0] base, input logic [3:0] bank);
        logic [7:0] f;
        f = w[7:0];
        if (w[8])
            file_addr = {bank, f};
        else if (ext && f <= ACCESS_LIMIT)
            file_addr = base + {4'h0, f};
        else if (f <= ACCESS_LIMIT)
            file_addr = {ACCESS_LOW_BANK, f};
        else
            file_addr = {ACCESS_HIGH_BANK, f};
    endfunction

    logic [1:0] q_r, q_nxt;
    logic [15:0] ir_r, ir_nxt;
    logic [PC_W-1:0] pc_r, pc_nxt;
    logic exec_r, exec_nxt;
    logic dead_r, dead_nxt;
    logic flush_r, flush_nxt;
    logic callhi_r, callhi_nxt;
    logic [7:0] klo_r, klo_nxt;
    logic [DADDR_W-1:0] addr_r, addr_nxt;
    logic re_r, re_nxt;
    logic we_r, we_nxt;
    logic [7:0] wd_r, wd_nxt;
    logic wwe_r, wwe_nxt;
    logic [7:0] ww_r, ww_nxt;
    logic [FLAG_W-1:0] fwe_r, fwe_nxt;
    logic [FLAG_W-1:0] fw_r, fw_nxt;
    logic push_r, push_nxt;
    logic [PC_W-1:0] rtop_r, rtop_nxt;
    logic [7:0] wsh_r, wsh_nxt;
    logic [FLAG_W-1:0] fsh_r, fsh_nxt;
    logic [7:0] bsh_r, bsh_nxt;
    logic wclr_r, wclr_nxt;
    logic tmo_r, tmo_nxt;
    logic pwrdn_r, pwrdn_nxt;
    logic dog_timeout;

    logic is_inv, is_br_ovf, is_br_zero, is_call, is_clr, is_wclr, is_com, is_eq, is_gt, is_lt;
    logic taken, cmp_skip, exec_go;
    logic [7:0] bit_mask;
    logic [7:0] inv_data;
    logic [PC_W-1:0] br_ofs;

    assign is_inv = ir_r[15:12] == OP_BIT_INVERT;
    assign is_br_ovf = ir_r[15:8] == OP_BRANCH_OVF;
    assign is_br_zero = ir_r[15:8] == OP_BRANCH_ZERO;
    assign is_call = ir_r[15:9] == OP_CALL;
    assign is_clr = ir_r[15:9] == OP_CLEAR_FILE;
    assign is_wclr = ir_r == OP_WATCHDOG_CLEAR;
    assign is_com = ir_r[15:10] == OP_COMPLEMENT;
    assign is_eq = ir_r[15:9] == OP_CMP_EQUAL;
    assign is_gt = ir_r[15:9] == OP_CMP_GREATER;
    assign is_lt = ir_r[15:9] == OP_CMP_LESS;
    assign bit_mask = 8'h01 << ir_r[11:9];
    assign inv_data = ~dmem_rdata;
    assign br_ofs = {{12{ir_r[7]}}, ir_r[7:0], 1'b0};
    assign taken = (is_br_ovf && status_in[FLAG_OV]) || (is_br_zero && status_in[FLAG_Z]);
    // unsigned compares, no flag is touched by any of them
    assign cmp_skip = (is_eq && dmem_rdata == working_register)
                   || (is_gt && dmem_rdata > working_register)
                   || (is_lt && dmem_rdata < working_register);
    assign exec_go = q_r == PH_PROCESS && exec_r && !callhi_r;

    watchdog_unit #(
        .CNT_W(WATCHDOG_CNT_W),
        .POST_W(WATCHDOG_POST_W)
    ) u_watchdog (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .clr(wclr_r),
        .timeout(dog_timeout)
    );

    always_comb begin
        q_nxt = q_r + 2'h1;
        ir_nxt = ir_r;
        pc_nxt = pc_r;
        exec_nxt = exec_r;
        dead_nxt = dead_r;
        flush_nxt = flush_r;
        callhi_nxt = callhi_r;
        klo_nxt = klo_r;
        addr_nxt = addr_r;
        re_nxt = re_r;
        we_nxt = 1'b0;
        wd_nxt = wd_r;
        wwe_nxt = 1'b0;
        ww_nxt = ww_r;
        fwe_nxt = '0;
        fw_nxt = fw_r;
        push_nxt = 1'b0;
        rtop_nxt = rtop_r;
        wsh_nxt = wsh_r;
        fsh_nxt = fsh_r;
        bsh_nxt = bsh_r;
        wclr_nxt = 1'b0;
        // a time-out pulse that overlaps the pending clear is dropped, the clear wins
        tmo_nxt = (dog_timeout && !wclr_r) ? 1'b0 : tmo_r;
        pwrdn_nxt = pwrdn_r;
        case (q_r)
            PH_DECODE: begin
                if (dead_r) begin
                    // second cycle of a taken branch: word ignored, pc held so the target is refetched
                    dead_nxt = 1'b0;
                    exec_nxt = 1'b0;
                end else begin
                    pc_nxt = pc_r + PC_STEP;
                    ir_nxt = instr_word;
                    if (callhi_r) begin
                        exec_nxt = 1'b0;
                    end else if (flush_r) begin
                        exec_nxt = 1'b0;
                        flush_nxt = two_word(instr_word);
                    end else begin
                        exec_nxt = 1'b1;
                        addr_nxt = file_addr(instr_word, ext_set_en, index_base, bank_select_reg[3:0]);
                        re_nxt = 1'b1;
                    end
                end
            end
            PH_PROCESS: begin
                re_nxt = 1'b0;
                if (callhi_r) begin
                    pc_nxt = {ir_r[11:0], klo_r, 1'b0};
                    callhi_nxt = 1'b0;
                end else if (exec_r) begin
                    if (is_inv) begin
                        we_nxt = 1'b1;
                        wd_nxt = dmem_rdata ^ bit_mask;
                    end
                    if (is_clr) begin
                        we_nxt = 1'b1;
                        wd_nxt = 8'h00;
                        fwe_nxt = MASK_Z;
                        fw_nxt = MASK_Z;
                    end
                    if (is_com) begin
                        if (ir_r[9]) begin
                            we_nxt = 1'b1;
                            wd_nxt = inv_data;
                        end else begin
                            wwe_nxt = 1'b1;
                            ww_nxt = inv_data;
                        end
                        fwe_nxt = MASK_NZ;
                        fw_nxt = '0;
                        fw_nxt[FLAG_N] = inv_data[7];
                        fw_nxt[FLAG_Z] = inv_data == 8'h00;
                    end
                    if (taken) begin
                        pc_nxt = pc_r + br_ofs;
                        dead_nxt = 1'b1;
                    end
                    if (cmp_skip)
                        flush_nxt = 1'b1;
                    if (is_call) begin
                        push_nxt = 1'b1;
                        rtop_nxt = pc_r + RET_OFS;
                        klo_nxt = ir_r[7:0];
                        callhi_nxt = 1'b1;
                        if (ir_r[8]) begin
                            wsh_nxt = working_register;
                            fsh_nxt = status_in;
                            bsh_nxt = bank_select_reg;
                        end
                    end
                    if (is_wclr) begin
                        // the clear wins over a time-out arriving in the same cycle
                        wclr_nxt = 1'b1;
                        tmo_nxt = 1'b1;
                        pwrdn_nxt = 1'b1;
                    end
                end
            end
            default: ;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            q_r <= PH_DECODE;
            ir_r <= 16'h0000;
            pc_r <= PC_RESET;
            exec_r <= 1'b0;
            dead_r <= 1'b0;
            flush_r <= 1'b0;
            callhi_r <= 1'b0;
            klo_r <= 8'h00;
            addr_r <= '0;
            re_r <= 1'b0;
            we_r <= 1'b0;
            wd_r <= 8'h00;
            wwe_r <= 1'b0;
            ww_r <= 8'h00;
            fwe_r <= '0;
            fw_r <= '0;
            push_r <= 1'b0;
            rtop_r <= PC_RESET;
            wsh_r <= 8'h00;
            fsh_r <= '0;
            bsh_r <= 8'h00;
            wclr_r <= 1'b0;
            tmo_r <= TIMEOUT_RST;
            pwrdn_r <= POWERDOWN_RST;
        end else begin
            q_r <= q_nxt;
            ir_r <= ir_nxt;
            pc_r <= pc_nxt;
            exec_r <= exec_nxt;
            dead_r <= dead_nxt;
            flush_r <= flush_nxt;
            callhi_r <= callhi_nxt;
            klo_r <= klo_nxt;
            addr_r <= addr_nxt;
            re_r <= re_nxt;
            we_r <= we_nxt;
            wd_r <= wd_nxt;
            wwe_r <= wwe_nxt;
            ww_r <= ww_nxt;
            fwe_r <= fwe_nxt;
            fw_r <= fw_nxt;
            push_r <= push_nxt;
            rtop_r <= rtop_nxt;
            wsh_r <= wsh_nxt;
            fsh_r <= fsh_nxt;
            bsh_r <= bsh_nxt;
            wclr_r <= wclr_nxt;
            tmo_r <= tmo_nxt;
            pwrdn_r <= pwrdn_nxt;
        end
    end

    assign fetch_addr = pc_r;
    assign phase = q_r;
    assign dmem_addr = addr_r;
    assign dmem_re = re_r;
    assign dmem_we = we_r;
    assign dmem_wdata = wd_r;
    assign w_we = wwe_r;
    assign w_wdata = ww_r;
    assign flags_we = fwe_r;
    assign flags_wdata = fw_r;
    assign ret_push = push_r;
    assign return_stack_top = rtop_r;
    assign working_shadow = wsh_r;
    assign flags_shadow = fsh_r;
    assign bank_select_shadow = bsh_r;
    assign timeout_flag = tmo_r;
    assign powerdown_flag = pwrdn_r;

    property p_invert;
        @(posedge ref_clk) disable iff (!rstn)
        exec_go && is_inv |=> dmem_we && dmem_wdata == ($past(dmem_rdata) ^ $past(bit_mask)) && flags_we == 5'h00;
    endproperty
    a_invert: assert property (p_invert) else $error("bit invert wrote wrong value or flags");

    property p_branch_ovf;
        @(posedge ref_clk) disable iff (!rstn)
        exec_go && is_br_ovf && status_in[FLAG_OV] |=> dead_r && pc_r == $past(pc_r) + $past(br_ofs) ##1 dead_r;
    endproperty
    a_branch_ovf: assert property (p_branch_ovf) else $error("overflow branch target wrong");

    property p_branch_zero_idle;
        @(posedge ref_clk) disable iff (!rstn)
        exec_go && is_br_zero && !status_in[FLAG_Z] |=> !dead_r && pc_r == $past(pc_r);
    endproperty
    a_branch_zero_idle: assert property (p_branch_zero_idle) else $error("zero branch taken with zero clear");

    property p_dead_cycle;
        @(posedge ref_clk) disable iff (!rstn)
        dead_r && q_r == PH_DECODE |=> !exec_r && !dead_r && $stable(pc_r);
    endproperty
    a_dead_cycle: assert property (p_dead_cycle) else $error("taken branch second cycle did work");

    property p_call_push;
        @(posedge ref_clk) disable iff (!rstn)
        exec_go && is_call |=> ret_push && return_stack_top == $past(pc_r) + RET_OFS ##4 !callhi_r;
    endproperty
    a_call_push: assert property (p_call_push) else $error("call push or length wrong");

    property p_call_noshadow;
        @(posedge ref_clk) disable iff (!rstn)
        exec_go && is_call && !ir_r[8] |=> $stable(working_shadow) && $stable(flags_shadow) && $stable(bank_select_shadow);
    endproperty
    a_call_noshadow: assert property (p_call_noshadow) else $error("shadows changed with save bit clear");

    property p_call_target;
        @(posedge ref_clk) disable iff (!rstn)
        callhi_r && q_r == PH_PROCESS |=> fetch_addr == {$past(ir_r[11:0]), $past(klo_r), 1'b0};
    endproperty
    a_call_target: assert property (p_call_target) else $error("call target wrong");

    property p_clear_file;
        @(posedge ref_clk) disable iff (!rstn)
        exec_go && is_clr |=> dmem_we && dmem_wdata == 8'h00 && flags_we == MASK_Z && flags_wdata[FLAG_Z];
    endproperty
    a_clear_file: assert property (p_clear_file) else $error("clear file result wrong");

    property p_banked;
        @(posedge ref_clk) disable iff (!rstn)
        q_r == PH_DECODE && !dead_r && !flush_r && !callhi_r && instr_word[8]
        |=> dmem_addr[11:8] == $past(bank_select_reg[3:0]);
    endproperty
    a_banked: assert property (p_banked) else $error("bank register not used");

    property p_indexed;
        @(posedge ref_clk) disable iff (!rstn)
        q_r == PH_DECODE && !dead_r && !flush_r && !callhi_r && !instr_word[8] && ext_set_en
        && instr_word[7:0] <= ACCESS_LIMIT |=> dmem_addr == $past(index_base) + {4'h0, $past(instr_word[7:0])};
    endproperty
    a_indexed: assert property (p_indexed) else $error("indexed literal offset address wrong");

    property p_watchdog;
        @(posedge ref_clk) disable iff (!rstn)
        exec_go && is_wclr |=> timeout_flag && powerdown_flag && wclr_r ##1 !wclr_r;
    endproperty
    a_watchdog: assert property (p_watchdog) else $error("watchdog clear effects wrong");

    property p_complement;
        @(posedge ref_clk) disable iff (!rstn)
        exec_go && is_com |=> flags_we == MASK_NZ && (dmem_we == $past(ir_r[9])) && (w_we != $past(ir_r[9]));
    endproperty
    a_complement: assert property (p_complement) else $error("complement destination or flags wrong");

    property p_skip_equal;
        @(posedge ref_clk) disable iff (!rstn)
        exec_go && is_eq && dmem_rdata == working_register |=> flush_r && flags_we == 5'h00 ##2 !exec_r;
    endproperty
    a_skip_equal: assert property (p_skip_equal) else $error("equal compare did not skip");

    property p_skip_greater;
        @(posedge ref_clk) disable iff (!rstn)
        exec_go && is_gt && dmem_rdata <= working_register |=> !flush_r;
    endproperty
    a_skip_greater: assert property (p_skip_greater) else $error("greater compare skipped wrongly");

    property p_skip_long;
        @(posedge ref_clk) disable iff (!rstn)
        flush_r && q_r == PH_DECODE && two_word(instr_word) |=> flush_r && !exec_r ##4 !flush_r && !exec_r;
    endproperty
    a_skip_long: assert property (p_skip_long) else $error("long word skip not three cycles");

    property p_skip_less;
        @(posedge ref_clk) disable iff (!rstn)
        exec_go && is_lt && dmem_rdata < working_register |=> flush_r && flags_we == 5'h00;
    endproperty
    a_skip_less: assert property (p_skip_less) else $error("less compare did not skip");
endmodule

// [bench/prog_data_model.sv]
// program memory and data memory seen from the execute block
`timescale 1ns/1ps
module prog_data_model (
    input wire logic ref_clk,
    input wire logic [exec_pkg::PC_W-1:0] fetch_addr,
    output logic [15:0] instr_word,
    input wire logic [exec_pkg::DADDR_W-1:0] dmem_addr,
    input wire logic dmem_re,
    input wire logic dmem_we,
    input wire logic [7:0] dmem_wdata,
    output logic [7:0] dmem_rdata
);
    import exec_pkg::*;
    logic [15:0] prog [0:255];
    logic [7:0] dmem [0:4095];
    // small program space, upper address bits alias onto it
    assign instr_word = prog[fetch_addr[8:1]];
    // read data is garbage outside the read strobe so a late sample shows up
    assign dmem_rdata = dmem_re ? dmem[dmem_addr] : ~dmem[dmem_addr];
    always @(posedge ref_clk) begin
        if (dmem_we) begin
            dmem[dmem_addr] <= dmem_wdata;
        end
    end
endmodule

// [bench/testbench.sv]
// self-checking bench for the instruction execute subset
`timescale 1ns/1ps
module testbench;
    import exec_pkg::*;
    `define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; $display("ERROR at %0t: got %h expected %h", $time, a, b); end end
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic ext_set_en = 1'b0;
    logic [11:0] index_base = 12'h000;
    logic [7:0] w = 8'h00;
    logic [7:0] bank_sel = 8'h00;
    logic [4:0] status = 5'h00;
    logic [15:0] instr_word;
    logic [7:0] dmem_rdata, dmem_wdata, w_wdata, working_shadow, bank_select_shadow;
    logic [20:0] fetch_addr, return_stack_top;
    logic [11:0] dmem_addr;
    logic [1:0] phase;
    logic dmem_re, dmem_we, w_we, ret_push, timeout_flag, powerdown_flag;
    logic [4:0] flags_we, flags_wdata, flags_shadow;
    int num_errors = 0;
    int total_checks = 0;
    int nwr, nw, nfl, npush, nre;
    logic [31:0] seed = 32'h0000DA7C;
    logic [31:0] r, r2;
    logic [11:0] waddr, ea;
    logic [7:0] wdata, wval, f, d, rs, n;
    logic [4:0] fm, fd, bitm;
    logic [20:0] top, tgt;
    logic [6:0] cops [0:2];
    logic a, skip;

    instr_exec i_dut (.ref_clk(ref_clk), .rstn(rstn), .instr_word(instr_word), .ext_set_en(ext_set_en),
        .index_base(index_base), .working_register(w), .status_in(status), .bank_select_reg(bank_sel),
        .dmem_rdata(dmem_rdata), .fetch_addr(fetch_addr), .phase(phase), .dmem_addr(dmem_addr),
        .dmem_re(dmem_re), .dmem_we(dmem_we), .dmem_wdata(dmem_wdata), .w_we(w_we), .w_wdata(w_wdata),
        .flags_we(flags_we), .flags_wdata(flags_wdata), .ret_push(ret_push), .return_stack_top(return_stack_top),
        .working_shadow(working_shadow), .flags_shadow(flags_shadow), .bank_select_shadow(bank_select_shadow),
        .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag));
    prog_data_model i_mem (.ref_clk(ref_clk), .fetch_addr(fetch_addr), .instr_word(instr_word),
        .dmem_addr(dmem_addr), .dmem_re(dmem_re), .dmem_we(dmem_we), .dmem_wdata(dmem_wdata),
        .dmem_rdata(dmem_rdata));

    always #2.5 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        if (dmem_we === 1'b1) begin nwr++; waddr = dmem_addr; wdata = dmem_wdata; end
        if (w_we === 1'b1) begin nw++; wval = w_wdata; end
        if (flags_we !== 5'h00) begin nfl++; fm = flags_we; fd = flags_wdata; end
        if (ret_push === 1'b1) begin npush++; top = return_stack_top; end
        if (dmem_re === 1'b1) nre++;
    end

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    function automatic logic [11:0] eaddr(logic acc, logic [7:0] fa);
        if (acc) return {bank_sel[3:0], fa};
        if (ext_set_en && fa <= ACCESS_LIMIT) return index_base + {4'h0, fa};
        return (fa <= ACCESS_LIMIT) ? {ACCESS_LOW_BANK, fa} : {ACCESS_HIGH_BANK, fa};
    endfunction

    task automatic clr_prog();
        for (int k = 0; k < 256; k++) i_mem.prog[k] = 16'h0000;
    endtask

    // each program starts from a fresh reset so counts cover one program only
    task automatic go(int cyc);
        @(posedge ref_clk);
        rstn <= 1'b0;
        @(posedge ref_clk);
        nwr = 0; nw = 0; nfl = 0; npush = 0; nre = 0;
        rstn <= 1'b1;
        repeat (cyc) @(posedge ref_clk);
        #1;
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        // budget well above the watchdog wait plus all programs
        #400000;
        num_errors++;
        $display("ERROR at %0t: run timed out", $time);
        complete_run();
    end

    initial begin
        cops[0] = OP_CMP_LESS; cops[1] = OP_CMP_EQUAL; cops[2] = OP_CMP_GREATER;
        repeat (12) @(posedge ref_clk);
        for (int i = 0; i < 12; i++) begin
            r = rnd(); r2 = rnd();
            a = r[0]; f = (i == 4) ? 8'h5F : r[8:1];
            ext_set_en <= r[9]; bank_sel <= r[18:11]; index_base <= r[30:19];
            d = (i == 2) ? 8'hFF : r2[7:0];
            #1;
            ea = eaddr(a, f);
            clr_prog();
            case (i % 3)
                0: i_mem.prog[0] = {OP_BIT_INVERT, i[2:0], a, f};
                1: i_mem.prog[0] = {OP_CLEAR_FILE, a, f};
                default: i_mem.prog[0] = {OP_COMPLEMENT, r[10], a, f};
            endcase
            i_mem.dmem[ea] = d;
            go(5);
            rs = ~d;
            case (i % 3)
                0: begin `CHK(waddr, ea); `CHK(wdata, d ^ (8'h01 << i[2:0])); `CHK(nfl, 0); end
                1: begin `CHK(waddr, ea); `CHK(wdata, 8'h00); `CHK(fm, MASK_Z); `CHK(fd[FLAG_Z], 1'b1); end
                default: begin
                    `CHK(fm, MASK_NZ);
                    `CHK(fd, {rs[7], 1'b0, rs == 8'h00, 2'b00});
                    `CHK(nw, r[10] ? 0 : 1);
                    if (r[10]) `CHK(wdata, rs);
                    if (!r[10]) `CHK(wval, rs);
                end
            endcase
            `CHK(nwr, (i % 3 == 2 && !r[10]) ? 0 : 1);
        end
        $display("file operations done");
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            n = (i == 2) ? 8'h80 : (i == 3) ? 8'h7F : r[7:0];
            bitm = 5'h01 << (i[0] ? FLAG_Z : FLAG_OV);
            status <= i[1] ? (r[12:8] | bitm) : (r[12:8] & ~bitm);
            clr_prog();
            i_mem.prog[0] = {i[0] ? OP_BRANCH_ZERO : OP_BRANCH_OVF, n};
            tgt = 21'h000002 + {{12{n[7]}}, n, 1'b0};
            go(3);
            `CHK(phase, PH_WRITE);
            `CHK(fetch_addr, i[1] ? tgt : 21'h000002);
            repeat (4) @(posedge ref_clk);
            #1;
            `CHK(fetch_addr, i[1] ? tgt : 21'h000004);
        end
        $display("branches done");
        for (int i = 0; i < 2; i++) begin
            r = rnd(); r2 = rnd();
            w <= r2[7:0]; status <= r2[12:8]; bank_sel <= r2[20:13];
            clr_prog();
            i_mem.prog[0] = {OP_CALL, i[0], r[7:0]};
            i_mem.prog[1] = {4'hF, r[19:8]};
            go(8);
            `CHK(npush, 1);
            `CHK(top, 21'h000004);
            `CHK(fetch_addr, {r[19:0], 1'b0});
            `CHK(working_shadow, i[0] ? w : 8'h00);
            `CHK(flags_shadow, i[0] ? status : 5'h00);
            `CHK(bank_select_shadow, i[0] ? bank_sel : 8'h00);
        end
        $display("calls done");
        for (int i = 0; i < 12; i++) begin
            r = rnd();
            w <= r[7:0]; bank_sel <= r[31:24]; status <= r[12:8];
            d = (i < 3) ? r[7:0] : r[15:8];
            f = r[23:16];
            #1;
            ea = eaddr(1'b1, f);
            skip = (i % 3 == 0) ? d < w : (i % 3 == 1) ? d == w : d > w;
            clr_prog();
            i_mem.prog[0] = {cops[i % 3], 1'b1, f};
            i_mem.prog[1] = 16'hEC00;
            i_mem.prog[2] = 16'hF000;
            i_mem.prog[3] = {OP_CLEAR_FILE, 1'b1, f ^ 8'h01};
            i_mem.dmem[ea] = d;
            go(17);
            `CHK(npush, skip ? 0 : 1);
            `CHK(nwr, skip ? 1 : 0);
            `CHK(nfl, skip ? 1 : 0);
            // discarded words never read data memory: two reads per executed word
            `CHK(nre, skip ? 4 : 6);
        end
        $display("compares done");
        clr_prog();
        i_mem.prog[0] = {OP_BRANCH_ZERO, 8'hFF};
        i_mem.prog[1] = OP_WATCHDOG_CLEAR;
        status <= MASK_Z;
        go(1);
        for (int k = 0; k < 30000 && timeout_flag !== 1'b0; k++) @(posedge ref_clk);
        #1;
        `CHK(timeout_flag, 1'b0);
        status <= 5'h00;
        repeat (12) @(posedge ref_clk);
        #1;
        `CHK(timeout_flag, 1'b1);
        `CHK(powerdown_flag, 1'b1);
        $display("watchdog clear done");
        complete_run();
    end
endmodule
